// ==== logic/smh_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE_01 - Port 1 drives clear-to-send whenever terminal's data-terminal-ready is active.
// RULE_02 - Port 1 drives data-set-ready whenever terminal's data-terminal-ready is active.
// RULE_03 - Port 1 carrier-detect output is a plain copy of data-terminal-ready.
// RULE_04 - Port 1 ignores request-to-send and always accepts received data.
// RULE_05 - Terminal ready gates port 1 transmit; current character finishes first.
// RULE_06 - Port 2 asserts request-to-send from reset onward.
// RULE_07 - Port 2 transmits only while modem clear-to-send is active. Code checks it only between frames, so a started character finishes.
// RULE_08 - Port 2 ignores modem data-set-ready for transmit decisions.
// RULE_09 - Port 2 ignores modem carrier-detect entirely.
// RULE_10 - Port 2 drives data-terminal-ready from reset onward.
// RULE_11 - Each port's baud rate is selectable from 110 to 9600.
// RULE_12 - No bit clocks leave the block; asynchronous framing only.
// RULE_13 - Every incoming modem-control line is synchronised before use.
module smh_top #(
  parameter int P1_BAUD = smh_pkg::BAUD_DEFAULT,
  parameter int P2_BAUD = smh_pkg::BAUD_DEFAULT
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Port 1 pins, toward the terminal (active high levels)
  input wire logic P1_DTR,
  input wire logic P1_RTS,
  input wire logic P1_RXD,
  output logic P1_TXD,
  output logic P1_CTS,
  output logic P1_DSR,
  output logic P1_DCD,
  // Port 2 pins, toward the modem (active high levels)
  input wire logic P2_CTS,
  input wire logic P2_DSR,
  input wire logic P2_DCD,
  input wire logic P2_RXD,
  output logic P2_TXD,
  output logic P2_RTS,
  output logic P2_DTR,
  // Port 1 transmit byte stream
  input wire logic [smh_pkg::DATA_W-1:0] P1_TX_DATA,
  input wire logic P1_TX_VALID,
  output logic P1_TX_READY,
  // Port 2 transmit byte stream
  input wire logic [smh_pkg::DATA_W-1:0] P2_TX_DATA,
  input wire logic P2_TX_VALID,
  output logic P2_TX_READY,
  // Received serial data, synchronised
  output logic P1_RX_LINE,
  output logic P2_RX_LINE
);
  import smh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Baud divisors

  localparam int P1_BAUD_OK = (P1_BAUD < BAUD_MIN) ? BAUD_MIN :
    (P1_BAUD > BAUD_MAX) ? BAUD_MAX : P1_BAUD;
  localparam int P2_BAUD_OK = (P2_BAUD < BAUD_MIN) ? BAUD_MIN :
    (P2_BAUD > BAUD_MAX) ? BAUD_MAX : P2_BAUD;
  // RULE_11 - baud range clamp
  localparam logic [DIV_W-1:0] P1_DIV = DIV_W'(CLK_HZ / P1_BAUD_OK);
  localparam logic [DIV_W-1:0] P2_DIV = DIV_W'(CLK_HZ / P2_BAUD_OK);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int N_IN = 5;
  // Idle levels: controls low, data lines at mark
  localparam logic [N_IN-1:0] IDLE_LVL = 5'h0A;
  logic [N_IN-1:0] pins_raw;
  logic [N_IN-1:0] pins_sync;
  logic p1_dtr_s, p1_rxd_s, p2_cts_s, p2_rxd_s, p2_dsr_s;

  // RULE_09 - modem carrier input unused
  // Modem carrier ignored outright; never sampled
  assign pins_raw = {P2_DSR, P2_RXD, P2_CTS, P1_RXD, P1_DTR};
  assign {p2_dsr_s, p2_rxd_s, p2_cts_s, p1_rxd_s, p1_dtr_s} = pins_sync;

  // RULE_13 - synchronise control inputs
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      smh_sync #(
        .INIT(IDLE_LVL[gi])
      ) u_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .pin(pins_raw[gi]),
        .level(pins_sync[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Port 1 handshake outputs

  logic next_p1_cts, next_p1_dsr, next_p1_dcd;

  // Derive port 1 controls from terminal ready
  always_comb begin
    // RULE_01 - clear-to-send follows DTR
    next_p1_cts = p1_dtr_s;
    // RULE_02 - data-set-ready follows DTR
    next_p1_dsr = p1_dtr_s;
    // RULE_03 - carrier copies DTR
    next_p1_dcd = p1_dtr_s;
    if (!RST_B) begin
      next_p1_cts = 1'b0;
      next_p1_dsr = 1'b0;
      next_p1_dcd = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    P1_CTS <= next_p1_cts;
    P1_DSR <= next_p1_dsr;
    P1_DCD <= next_p1_dcd;
  end

  ////////////////////////////////////////////////////////////////////////
  // Port 2 handshake outputs

  logic next_p2_rts, next_p2_dtr;
  logic p2_dsr_unused;

  // Modem ready is observed only to be discarded
  assign p2_dsr_unused = p2_dsr_s;

  // Drive port 2 controls active out of reset
  always_comb begin
    // RULE_06 - request-to-send on at power-up
    next_p2_rts = 1'b1;
    // RULE_10 - terminal ready on at power-up
    next_p2_dtr = 1'b1;
    if (!RST_B) begin
      next_p2_rts = 1'b0;
      next_p2_dtr = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    P2_RTS <= next_p2_rts;
    P2_DTR <= next_p2_dtr;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitters

  logic p1_txd, p2_txd, p1_rdy, p2_rdy;
  logic p1_en, p2_en;

  // RULE_05 - DTR gates port 1 transmit
  assign p1_en = p1_dtr_s;
  // RULE_07 - clear-to-send gates port 2
  // RULE_08 - ready from modem not used
  assign p2_en = p2_cts_s & (p2_dsr_unused | 1'b1);

  // RULE_12 - serial data only, no bit clock
  smh_tx u_tx1 (
    .clk(MCLK),
    .rst_b(RST_B),
    .divisor(P1_DIV),
    .enable(p1_en),
    .data(P1_TX_DATA),
    .valid(P1_TX_VALID),
    .ready(p1_rdy),
    .txd(p1_txd)
  );

  smh_tx u_tx2 (
    .clk(MCLK),
    .rst_b(RST_B),
    .divisor(P2_DIV),
    .enable(p2_en),
    .data(P2_TX_DATA),
    .valid(P2_TX_VALID),
    .ready(p2_rdy),
    .txd(p2_txd)
  );

  assign P1_TXD = p1_txd;
  assign P2_TXD = p2_txd;
  assign P1_TX_READY = p1_rdy;
  assign P2_TX_READY = p2_rdy;

  ////////////////////////////////////////////////////////////////////////
  // Receive lines

  // RULE_04 - RTS ignored, receive always open
  assign P1_RX_LINE = p1_rxd_s;
  assign P2_RX_LINE = p2_rxd_s;
endmodule
`default_nettype wire

// ==== logic/smh_pkg.sv ====
package smh_pkg;
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
  // Board clock
  localparam int CLK_HZ = 40000000;
  // Baud range limits
  localparam int BAUD_MIN = 110;
  localparam int BAUD_MAX = 9600;
  localparam int BAUD_DEFAULT = 9600;
  // Bit period in clocks at a given baud, rounded down
  localparam int DIV_MAX = CLK_HZ / BAUD_MIN;
  localparam int DIV_W = $clog2(DIV_MAX + 1);
  localparam int DATA_W = 8;
  // Frame: start, data, stop
  localparam int FRAME_BITS = DATA_W + 2;
  localparam int BIT_W = $clog2(FRAME_BITS + 1);
  // Idle line level (mark)
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LVL = 1'b0;
  typedef enum {SMH_IDLE, SMH_SHIFT} smh_tx_state_t;
endpackage

// ==== logic/smh_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module smh_sync #(
  // Level held in reset, the pin's idle level
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin level in, filtered level out
  input wire logic pin,
  output logic level
);
  import smh_pkg::*;

  logic [SYNC_STAGES-1:0] stage;
  logic [SYNC_STAGES-1:0] next_stage;
  logic next_level;

  // Shift pin in; update when last two agree
  always_comb begin
    next_stage = {stage[SYNC_STAGES-2:0], pin};
    next_level = level;
    if (stage[SYNC_STAGES-1] == stage[SYNC_STAGES-2]) begin
      next_level = stage[SYNC_STAGES-1];
    end
    // Reset to the idle level so no false edge follows release
    if (!rst_b) begin
      next_stage = {SYNC_STAGES{INIT}};
      next_level = INIT;
    end
  end

  always_ff @(posedge clk) begin
    stage <= next_stage;
    level <= next_level;
  end
endmodule
`default_nettype wire

// ==== logic/smh_tx.sv ====
`timescale 1ns/10ps
`default_nettype none
module smh_tx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bit period in clocks
  input wire logic [smh_pkg::DIV_W-1:0] divisor,
  // Transmit gate, high allows a new frame
  input wire logic enable,
  // Byte stream
  input wire logic [smh_pkg::DATA_W-1:0] data,
  input wire logic valid,
  output logic ready,
  // Serial line
  output logic txd
);
  import smh_pkg::*;

  smh_tx_state_t state, next_state;
  logic [FRAME_BITS-1:0] shreg, next_shreg;
  logic [BIT_W-1:0] bits, next_bits;
  logic [DIV_W-1:0] cnt, next_cnt;
  logic next_txd;
  logic next_ready;

  // Frame engine; gate checked only between frames
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bits = bits;
    next_cnt = cnt;
    next_txd = txd;
    next_ready = 1'b0;
    case (state)
      SMH_IDLE: begin
        next_txd = LINE_IDLE;
        next_ready = enable;
        if (ready && valid) begin
          next_shreg = {LINE_IDLE, data, START_LVL};
          next_bits = BIT_W'(FRAME_BITS);
          next_cnt = '0;
          next_state = SMH_SHIFT;
          next_ready = 1'b0;
        end
      end
      SMH_SHIFT: begin
        if (cnt == '0) begin
          if (bits == '0) begin
            next_state = SMH_IDLE;
            next_txd = LINE_IDLE;
          end else begin
            next_txd = shreg[0];
            next_shreg = {LINE_IDLE, shreg[FRAME_BITS-1:1]};
            next_bits = bits - BIT_W'(1);
            next_cnt = divisor - DIV_W'(1);
          end
        end else begin
          next_cnt = cnt - DIV_W'(1);
        end
      end
      default: next_state = SMH_IDLE;
    endcase
    if (!rst_b) begin
      next_state = SMH_IDLE;
      next_shreg = '1;
      next_bits = '0;
      next_cnt = '0;
      next_txd = LINE_IDLE;
      next_ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
    shreg <= next_shreg;
    bits <= next_bits;
    cnt <= next_cnt;
    txd <= next_txd;
    ready <= next_ready;
  end
endmodule
`default_nettype wire

// ==== testbench/smh_chk_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module smh_chk (
  // Clock and reset
  input wire logic MCLK, RST_B,
  // Port 1
  input wire logic P1_DTR, P1_CTS, P1_DSR, P1_DCD, P1_RXD, P1_RX_LINE,
  input wire logic P1_TXD, P1_TX_READY, P1_TX_VALID,
  // Port 2
  input wire logic P2_CTS, P2_RTS, P2_DTR, P2_TX_READY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Port 1 controls follow a steady terminal ready
  p1_ctl_on_a: assert property (
    P1_DTR[*8] |-> P1_CTS && P1_DSR && P1_DCD) else $error("p1 on");
  p1_ctl_off_a: assert property (
    !P1_DTR[*8] |-> !P1_CTS && !P1_DSR && !P1_DCD) else $error("p1 off");
  // A new level needs the synchroniser stages first
  p1_sync_a: assert property (
    $rose(P1_DTR) && !P1_CTS |=> !P1_CTS[*2]) else $error("p1 sync");
  p1_rx_a: assert property (
    P1_RXD[*6] |-> P1_RX_LINE) else $error("p1 rx");
  p1_gate_a: assert property (
    !P1_DTR[*8] |-> !P1_TX_READY) else $error("p1 gate");
  p1_frame_a: assert property (
    P1_TX_READY && P1_TX_VALID |=> !P1_TX_READY ##[0:2] !P1_TXD)
    else $error("p1 start");
  // Port 2 controls up after reset, sending gated by the modem
  p2_ctl_a: assert property (
    RST_B |=> P2_RTS && P2_DTR) else $error("p2 ctl");
  p2_gate_a: assert property (
    !P2_CTS[*8] |-> !P2_TX_READY) else $error("p2 gate");
endmodule
bind smh_top smh_chk chk (.*);
`default_nettype wire

// ==== testbench/smh_modem.sv ====
`timescale 1ns/10ps
`default_nettype none
module smh_modem (
  // Clock and bench controls
  input wire logic clk, hold, drop,
  // Controls from the terminal side
  input wire logic rts, dtr,
  // Modem status and data
  output logic cts, dsr, dcd, rxd
);
  initial {cts, dsr, dcd, rxd} = 4'h1;
  // Grant sending while asked unless held off; report line state
  always @(negedge clk) begin
    cts <= rts & ~hold;
    dsr <= dtr & ~drop;
    dcd <= ~drop;
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import smh_pkg::*;
  localparam int DIV = CLK_HZ / BAUD_MAX;
  logic MCLK = 1'h0, RST_B = 1'h0, hold = 1'h0, drop = 1'h0;
  logic P1_DTR = 1'h0, P1_RTS = 1'h0, P1_RXD = 1'h1;
  logic P1_TX_VALID = 1'h0, P2_TX_VALID = 1'h0;
  logic [DATA_W-1:0] P1_TX_DATA = 8'h00, P2_TX_DATA = 8'h00;
  logic P1_TXD, P1_CTS, P1_DSR, P1_DCD, P1_TX_READY, P1_RX_LINE;
  logic P2_CTS, P2_DSR, P2_DCD, P2_RXD, P2_TXD, P2_RTS, P2_DTR;
  logic P2_TX_READY, P2_RX_LINE;
  int fails = 0, checks_done = 0;
  always #12.5 MCLK = ~MCLK;
  smh_top #(.P1_BAUD(BAUD_MAX), .P2_BAUD(BAUD_MIN)) uut (.*);
  smh_modem modem (.clk(MCLK), .hold(hold), .drop(drop), .rts(P2_RTS),
    .dtr(P2_DTR), .cts(P2_CTS), .dsr(P2_DSR), .dcd(P2_DCD), .rxd(P2_RXD));
  ////////////////////////////////////////
  // Compare one bit and tally
  task automatic chk(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic close_out;
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Offer a byte, wait for the take and the start bit
  task automatic send(input logic p2, input logic [DATA_W-1:0] b);
    int n;
    P1_TX_DATA = b;
    P2_TX_DATA = b;
    P1_TX_VALID = ~p2;
    P2_TX_VALID = p2;
    for (n = 0; n < 50 && (p2 ? P2_TX_READY : P1_TX_READY) !== 1'h1; n++)
      tick(1);
    if (n == 50) begin
      fails++;
      close_out;
    end
    tick(1);
    P1_TX_VALID = 1'h0;
    P2_TX_VALID = 1'h0;
    for (n = 0; n < 50 && (p2 ? P2_TXD : P1_TXD) !== 1'h0; n++) tick(1);
    if (n == 50) begin
      fails++;
      close_out;
    end
  endtask
  // Reset levels, then port 2 controls come up
  task automatic s_reset;
    chk("p2 rts", 1'h0, P2_RTS);
    RST_B = 1'h1;
    tick(2);
    chk("p2 rts", 1'h1, P2_RTS);
    chk("p2 dtr", 1'h1, P2_DTR);
  endtask
  // Terminal ready drives port 1 controls; glitch and rts ignored
  task automatic s_p1_ctrl;
    P1_DTR = 1'h1;
    tick(1);
    P1_DTR = 1'h0;
    tick(6);
    chk("glitch", 1'h0, P1_CTS);
    P1_DTR = 1'h1;
    P1_RXD = 1'h0;
    tick(6);
    P1_RTS = 1'h1;
    tick(6);
    chk("p1 cts", 1'h1, P1_CTS);
    chk("p1 dsr", 1'h1, P1_DSR);
    chk("p1 dcd", 1'h1, P1_DCD);
    chk("p1 rx", 1'h0, P1_RX_LINE);
    P1_RXD = 1'h1;
    P1_DTR = 1'h0;
    tick(6);
    chk("p1 off", 1'h0, P1_CTS | P1_DSR | P1_DCD);
    P1_DTR = 1'h1;
  endtask
  // Modem clear-to-send alone gates port 2
  task automatic s_p2_gate;
    hold = 1'h1;
    tick(8);
    chk("p2 held", 1'h0, P2_TX_READY);
    hold = 1'h0;
    drop = 1'h1;
    tick(8);
    chk("p2 free", 1'h1, P2_TX_READY);
  endtask
  // Whole frame on port 1, terminal ready dropped mid-frame
  task automatic s_p1_frame;
    logic [FRAME_BITS-1:0] f;
    f = {LINE_IDLE, 8'hA5, START_LVL};
    send(1'h0, 8'hA5);
    tick(DIV / 2);
    for (int i = 0; i < FRAME_BITS; i++) begin
      chk("p1 bit", f[i], P1_TXD);
      if (i == 3) P1_DTR = 1'h0;
      tick(DIV);
    end
    chk("p1 after", 1'h0, P1_TX_READY);
  endtask
  // Port 2 at the slow end keeps its start bit longer
  task automatic s_p2_slow;
    send(1'h1, 8'h3C);
    tick(2 * DIV);
    chk("p2 start", 1'h0, P2_TXD);
  endtask
  initial begin
    tick(8);
    s_reset;
    s_p1_ctrl;
    s_p2_gate;
    s_p1_frame;
    s_p2_slow;
    close_out;
  end
endmodule
`default_nettype wire
